// *** logic/adsq_top.sv ***
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "adsq_regs.svh"
module adsq_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              mclk_i,
    input  wire logic              resetn_i,
    input  wire logic              stop_mode_i,
    input  wire logic              cmp_hi_i,
    output logic      [9:0]        dac_code_o,
    output logic                   sample_o,
    output logic      [2:0]        channel_o,
    output logic      [2:0]        port_cfg_o,
    output logic                   cmp_enable_o,
    output logic                   conv_done_irq_o,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    adsq_pkg::adsq_regs_t r_r;
    adsq_pkg::adsq_regs_t r_nxt;

    logic       wr_fire;
    logic       rd_fire;
    logic [7:0] waddr;
    logic [7:0] raddr;
    logic       wr_en;
    logic       cfg_wr;
    logic       chsel_wr;
    logic       rd_res;
    logic       step_end;
    logic       eoc;
    logic [9:0] eoc_val;

    assign wr_fire  = s_axi_awvalid & s_axi_wvalid & r_r.awready;
    assign rd_fire  = s_axi_arvalid & r_r.arready;
    assign waddr    = 8'(s_axi_awaddr);
    assign raddr    = 8'(s_axi_araddr);
    assign wr_en    = wr_fire & s_axi_wstrb[0];
    assign chsel_wr = wr_en & (waddr == `ADSQ_OFS_CHSEL);
    assign cfg_wr   = wr_en & ((waddr == `ADSQ_OFS_MODE) | chsel_wr
                      | (waddr == `ADSQ_OFS_PCFG));
    assign rd_res   = rd_fire & ((raddr == `ADSQ_OFS_RESW) | (raddr == `ADSQ_OFS_RESB));
    assign step_end = (r_r.st == adsq_pkg::ADSQ_CONVERT)
                      & (r_r.cnt == {1'b0, r_r.mode[`ADSQ_MODE_THI:`ADSQ_MODE_TLO]});
    assign eoc      = step_end & (r_r.idx == 4'h0) & r_r.mode[`ADSQ_MODE_RUN] & ~stop_mode_i;
    assign eoc_val  = {r_r.sar[9:1], cmp_hi_i};

    always_comb begin
        logic       do_wr;
        logic [9:0] wval;
        r_nxt = r_r;
        do_wr = 1'b0;
        wval  = r_r.pend_val;
        // conversion sequencer
        if (stop_mode_i || !r_r.mode[`ADSQ_MODE_RUN]) begin
            r_nxt.st  = adsq_pkg::ADSQ_IDLE;
            r_nxt.cnt = 7'h00;
        end else begin
            unique case (r_r.st)
                adsq_pkg::ADSQ_IDLE: begin
                    r_nxt.st  = adsq_pkg::ADSQ_SAMPLE;
                    r_nxt.cnt = 7'h00;
                end
                adsq_pkg::ADSQ_SAMPLE: begin
                    r_nxt.cnt = r_r.cnt + 7'h01;
                    if (r_r.cnt == `ADSQ_SAMPLE_CYC - 7'h01) begin
                        r_nxt.st  = adsq_pkg::ADSQ_CONVERT;
                        r_nxt.cnt = 7'h00;
                        r_nxt.idx = `ADSQ_MSB_IDX;
                        r_nxt.sar = `ADSQ_SAR_FIRST;
                    end
                end
                adsq_pkg::ADSQ_CONVERT: begin
                    r_nxt.cnt = r_r.cnt + 7'h01;
                    if (step_end) begin
                        r_nxt.cnt = 7'h00;
                        r_nxt.sar[r_r.idx] = cmp_hi_i;
                        if (r_r.idx == 4'h0) begin
                            r_nxt.st = adsq_pkg::ADSQ_SAMPLE;
                        end else begin
                            r_nxt.idx = r_r.idx - 4'h1;
                            r_nxt.sar[r_r.idx - 4'h1] = 1'b1;
                        end
                    end
                end
                default: r_nxt.st = adsq_pkg::ADSQ_IDLE;
            endcase
        end
        if (chsel_wr) begin
            r_nxt.st  = adsq_pkg::ADSQ_IDLE;
            r_nxt.cnt = 7'h00;
        end
        r_nxt.sample = (r_nxt.st == adsq_pkg::ADSQ_SAMPLE);
        // result write-back and conflicts
        r_nxt.pend = 1'b0;
        if (eoc && !cfg_wr) begin
            if (rd_res) begin
                r_nxt.pend     = 1'b1;
                r_nxt.pend_val = eoc_val;
            end else begin
                do_wr = 1'b1;
                wval  = eoc_val;
            end
        end else if (r_r.pend && !cfg_wr) begin
            do_wr = 1'b1;
        end
        // a configuration write drops any result in flight
        if (do_wr) begin
            r_nxt.res_w = {wval, 6'h00};
            r_nxt.res_b = wval[9:2];
        end
        // done flag: set wins over clear, channel writes leave it alone
        r_nxt.stat = (r_r.stat & ~(wr_en && waddr == `ADSQ_OFS_STAT
                      && s_axi_wdata[`ADSQ_STAT_DONE])) | do_wr;
        // register writes
        if (wr_en) begin
            unique case (waddr)
                `ADSQ_OFS_MODE:  r_nxt.mode  = s_axi_wdata[7:0];
                `ADSQ_OFS_CHSEL: r_nxt.chsel = s_axi_wdata[2:0];
                `ADSQ_OFS_PCFG:  r_nxt.pcfg  = s_axi_wdata[2:0];
                `ADSQ_OFS_MASK:  r_nxt.mask  = s_axi_wdata[`ADSQ_STAT_DONE];
                default: ;
            endcase
        end
        r_nxt.irq = r_nxt.stat & r_nxt.mask;
        // write channel
        r_nxt.awready = s_axi_awvalid & s_axi_wvalid & ~r_r.awready & ~r_r.bvalid;
        r_nxt.wready  = r_nxt.awready;
        if (wr_fire) begin
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp  = (waddr == `ADSQ_OFS_MODE || waddr == `ADSQ_OFS_CHSEL
                            || waddr == `ADSQ_OFS_PCFG || waddr == `ADSQ_OFS_STAT
                            || waddr == `ADSQ_OFS_MASK || waddr == `ADSQ_OFS_RESW
                            || waddr == `ADSQ_OFS_RESB) ? `ADSQ_RESP_OKAY : `ADSQ_RESP_SLVERR;
        end else if (s_axi_bready) begin
            r_nxt.bvalid = 1'b0;
        end
        // read channel
        r_nxt.arready = s_axi_arvalid & ~r_r.arready & ~r_r.rvalid;
        if (rd_fire) begin
            r_nxt.rvalid = 1'b1;
            r_nxt.rresp  = `ADSQ_RESP_OKAY;
            unique case (raddr)
                `ADSQ_OFS_MODE:  r_nxt.rdata = {24'h000000, r_r.mode};
                `ADSQ_OFS_CHSEL: r_nxt.rdata = {29'h00000000, r_r.chsel};
                `ADSQ_OFS_PCFG:  r_nxt.rdata = {29'h00000000, r_r.pcfg};
                `ADSQ_OFS_RESW:  r_nxt.rdata = {16'h0000, r_r.res_w};
                `ADSQ_OFS_RESB:  r_nxt.rdata = {24'h000000, r_r.res_b};
                `ADSQ_OFS_STAT:  r_nxt.rdata = {31'h00000000, r_r.stat};
                `ADSQ_OFS_MASK:  r_nxt.rdata = {31'h00000000, r_r.mask};
                default: begin
                    r_nxt.rdata = 32'h00000000;
                    r_nxt.rresp = `ADSQ_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            r_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            r_r         <= '0;
            r_r.st      <= adsq_pkg::ADSQ_IDLE;
            r_r.mode    <= `ADSQ_RST_MODE;
            r_r.chsel   <= `ADSQ_RST_CHSEL;
            r_r.pcfg    <= `ADSQ_RST_PCFG;
            r_r.res_w   <= `ADSQ_RST_RESW;
            r_r.res_b   <= `ADSQ_RST_RESB;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign dac_code_o      = r_r.sar;
    assign sample_o        = r_r.sample;
    assign channel_o       = r_r.chsel;
    assign port_cfg_o      = r_r.pcfg;
    assign cmp_enable_o    = r_r.mode[`ADSQ_MODE_CMPEN];
    assign conv_done_irq_o = r_r.irq;
    assign s_axi_awready   = r_r.awready;
    assign s_axi_wready    = r_r.wready;
    assign s_axi_bvalid    = r_r.bvalid;
    assign s_axi_bresp     = r_r.bresp;
    assign s_axi_arready   = r_r.arready;
    assign s_axi_rvalid    = r_r.rvalid;
    assign s_axi_rresp     = r_r.rresp;
    assign s_axi_rdata     = r_r.rdata;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    property p_stop_idle;
        stop_mode_i |=> r_r.st == adsq_pkg::ADSQ_IDLE && !eoc;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("conversion ran in stop mode");

    property p_read_first;
        eoc && rd_res && !cfg_wr |=> r_r.pend && $stable(r_r.res_w)
            ##1 (r_r.stat && r_r.res_w == {$past(eoc_val, 2), 6'h00} || $past(cfg_wr));
    endproperty
    a_read_first: assert property (p_read_first) else $error("read did not win");

    property p_cfg_drop;
        eoc && cfg_wr |=> $stable(r_r.res_w) && $stable(r_r.res_b) && !r_r.pend
            && r_r.stat == $past(r_r.stat);
    endproperty
    a_cfg_drop: assert property (p_cfg_drop) else $error("result written on config");

    property p_chsel_keeps_flag;
        chsel_wr && r_r.stat |=> r_r.stat;
    endproperty
    a_chsel_keeps_flag: assert property (p_chsel_keeps_flag) else $error("flag cleared");

    property p_chsel_restart;
        chsel_wr |=> r_r.st == adsq_pkg::ADSQ_IDLE && r_r.cnt == 7'h00;
    endproperty
    a_chsel_restart: assert property (p_chsel_restart) else $error("no restart");

    property p_run_off;
        !r_r.mode[`ADSQ_MODE_RUN] && !r_r.pend |=> r_r.st == adsq_pkg::ADSQ_IDLE
            && $stable(r_r.res_w);
    endproperty
    a_run_off: assert property (p_run_off) else $error("run cleared but busy");

    property p_continuous;
        eoc && !chsel_wr |=> r_r.st == adsq_pkg::ADSQ_SAMPLE;
    endproperty
    a_continuous: assert property (p_continuous) else $error("no next conversion");

    property p_reset_clear;
        @(posedge mclk_i) disable iff (1'b0)
        !resetn_i |=> r_r.res_w == 16'h0000 && r_r.res_b == 8'h00 && !r_r.irq;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("result not cleared");

    property p_done_irq;
        $rose(r_r.stat) |-> $changed(r_r.res_w) || $past(r_r.pend) || $past(eoc)
            ##0 (r_r.irq == r_r.mask);
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("flag without irq");

endmodule

// *** shared/adsq_pkg.sv ***
package adsq_pkg;

    typedef enum logic [1:0] {
        ADSQ_IDLE    = 2'b00,
        ADSQ_SAMPLE  = 2'b01,
        ADSQ_CONVERT = 2'b11
    } adsq_state_t;

    typedef struct packed {
        adsq_state_t st;
        logic [6:0]  cnt;
        logic [3:0]  idx;
        logic [9:0]  sar;
        logic        sample;
        logic [7:0]  mode;
        logic [2:0]  chsel;
        logic [2:0]  pcfg;
        logic [15:0] res_w;
        logic [7:0]  res_b;
        logic        pend;
        logic [9:0]  pend_val;
        logic        stat;
        logic        mask;
        logic        irq;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } adsq_regs_t;

endpackage

// *** shared/adsq_regs.svh ***
`ifndef ADSQ_REGS_SVH
`define ADSQ_REGS_SVH

// register byte offsets
`define ADSQ_OFS_MODE    8'h00
`define ADSQ_OFS_CHSEL   8'h04
`define ADSQ_OFS_PCFG    8'h08
`define ADSQ_OFS_RESW    8'h0C
`define ADSQ_OFS_RESB    8'h10
`define ADSQ_OFS_STAT    8'h14
`define ADSQ_OFS_MASK    8'h18

// field positions
`define ADSQ_MODE_RUN    7
`define ADSQ_MODE_CMPEN  0
`define ADSQ_MODE_TLO    1
`define ADSQ_MODE_THI    6
`define ADSQ_STAT_DONE   0

// reset values
`define ADSQ_RST_MODE    8'h00
`define ADSQ_RST_CHSEL   3'h0
`define ADSQ_RST_PCFG    3'h0
`define ADSQ_RST_RESW    16'h0000
`define ADSQ_RST_RESB    8'h00

// sample count in clock cycles, first trial bit index and first trial code
`define ADSQ_SAMPLE_CYC  7'h04
`define ADSQ_MSB_IDX     4'h9
`define ADSQ_SAR_FIRST   10'h200

// bus answers
`define ADSQ_RESP_OKAY   2'h0
`define ADSQ_RESP_SLVERR 2'h2

`endif

// *** tb/adsq_ana_model.sv ***
`timescale 1ns/1ps
// analog side: one level per input channel, compared against the trial code
module adsq_ana_model #(
    parameter logic [9:0] LVL0 = 10'h200,
    parameter logic [9:0] LVL1 = 10'h100
) (
    input  wire logic [9:0] dac_code_i,
    input  wire logic [2:0] channel_i,
    input  wire logic       cmp_enable_i,
    output logic            cmp_hi_o
);
    logic [9:0] lvl;
    assign lvl = (channel_i == 3'h0) ? LVL0 : (channel_i == 3'h1) ? LVL1 : 10'h000;
    // a disabled comparator never reports high
    assign cmp_hi_o = cmp_enable_i && (lvl >= dac_code_i);
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`include "adsq_regs.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin mismatches++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tb_top;
    localparam logic [9:0] CODE0 = 10'h2A5;
    localparam logic [9:0] CODE1 = 10'h133;
    logic        mclk_i = 1'b0;
    logic        resetn_i, stop_mode_i, cmp, cen, smp, irq;
    logic [9:0]  dac;
    logic [2:0]  ch, pc;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          mismatches = 0;
    int          tests_run = 0;
    int          hi;

    always #50 mclk_i = ~mclk_i;

    adsq_top i_adsq_top (.mclk_i(mclk_i), .resetn_i(resetn_i), .stop_mode_i(stop_mode_i),
        .cmp_hi_i(cmp), .dac_code_o(dac), .sample_o(smp), .channel_o(ch), .port_cfg_o(pc),
        .cmp_enable_o(cen), .conv_done_irq_o(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    adsq_ana_model #(.LVL0(CODE0), .LVL1(CODE1)) u_ana (.dac_code_i(dac), .channel_i(ch),
        .cmp_enable_i(cen), .cmp_hi_o(cmp));

    task automatic tally_and_finish();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        bit aw_t, w_t, b_t;
        n = 0;
        @(posedge mclk_i);
        awaddr <= a; awvalid <= 1'b1; wdata <= v; wstrb <= 4'hF; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(negedge mclk_i);
            n++;
            if (n > 100) begin mismatches++; tally_and_finish(); end
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bready && bvalid;
            if (b_t) `CHK("bresp", `ADSQ_RESP_OKAY, bresp)
            @(posedge mclk_i);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) bready <= 1'b0;
        end while (!b_t);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        bit ar_t, r_t;
        n = 0;
        @(posedge mclk_i);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(negedge mclk_i);
            n++;
            if (n > 100) begin mismatches++; tally_and_finish(); end
            ar_t = arvalid && arready;
            r_t = rready && rvalid;
            v = rdata;
            rs = rresp;
            @(posedge mclk_i);
            if (ar_t) arvalid <= 1'b0;
            if (r_t) rready <= 1'b0;
        end while (!r_t);
    endtask

    task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
        logic [31:0] v;
        logic [1:0]  rs;
        rd(a, v, rs);
        `CHK(nm, ex, v)
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        do begin
            @(negedge mclk_i);
            n++;
            if (n > 300) begin mismatches++; tally_and_finish(); end
        end while (irq !== 1'b1);
        `CHK("irq", 1'b1, irq)
    endtask

    // counts cycles with the interrupt high over a quiet stretch
    task automatic quiet(input int cyc, output int h);
        h = 0;
        repeat (cyc) begin
            @(negedge mclk_i);
            if (irq !== 1'b0) h++;
        end
    endtask

    initial begin
        resetn_i = 1'b0; stop_mode_i = 1'b0; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0;
        wstrb = 4'h0; wvalid = 1'b0; bready = 1'b0; araddr = 8'h00; arvalid = 1'b0;
        rready = 1'b0;
        repeat (4) @(posedge mclk_i);
        resetn_i <= 1'b1;
        chk_rd("res_word", `ADSQ_OFS_RESW, {16'h0, `ADSQ_RST_RESW});
        chk_rd("res_byte", `ADSQ_OFS_RESB, {24'h0, `ADSQ_RST_RESB});
        rd(8'h1C, d, r);
        `CHK("unmapped", `ADSQ_RESP_SLVERR, r)
        wr(`ADSQ_OFS_MASK, 32'h1);
        wr(`ADSQ_OFS_MODE, 32'h01);
        repeat (10) @(posedge mclk_i);
        wr(`ADSQ_OFS_MODE, 32'h81);
        wait_irq();
        chk_rd("stat", `ADSQ_OFS_STAT, 32'h1);
        chk_rd("word0", `ADSQ_OFS_RESW, {16'h0, CODE0, 6'h0});
        chk_rd("byte0", `ADSQ_OFS_RESB, {24'h0, CODE0[9:2]});
        wr(`ADSQ_OFS_STAT, 32'h1);
        wait_irq();
        wr(`ADSQ_OFS_CHSEL, 32'h1);
        chk_rd("stat_kept", `ADSQ_OFS_STAT, 32'h1);
        wr(`ADSQ_OFS_STAT, 32'h1);
        wait_irq();
        chk_rd("word1", `ADSQ_OFS_RESW, {16'h0, CODE1, 6'h0});
        wr(`ADSQ_OFS_MASK, 32'h0);
        wr(`ADSQ_OFS_STAT, 32'h1);
        quiet(60, hi);
        `CHK("masked", 0, hi)
        chk_rd("stat_run", `ADSQ_OFS_STAT, 32'h1);
        wr(`ADSQ_OFS_MASK, 32'h1);
        wait_irq();
        wr(`ADSQ_OFS_MODE, 32'h01);
        wr(`ADSQ_OFS_STAT, 32'h1);
        quiet(60, hi);
        `CHK("sample_idle", 1'b0, smp)
        `CHK("irq_stop", 0, hi)
        chk_rd("stat_stop", `ADSQ_OFS_STAT, 32'h0);
        chk_rd("word_kept", `ADSQ_OFS_RESW, {16'h0, CODE1, 6'h0});
        wr(`ADSQ_OFS_MODE, 32'h00);
        @(posedge mclk_i);
        stop_mode_i <= 1'b1;
        wr(`ADSQ_OFS_MODE, 32'h01);
        repeat (10) @(posedge mclk_i);
        wr(`ADSQ_OFS_MODE, 32'h81);
        quiet(60, hi);
        `CHK("sample_lowpw", 1'b0, smp)
        chk_rd("stat_lowpw", `ADSQ_OFS_STAT, 32'h0);
        `CHK("irq_lowpw", 0, hi)
        wr(`ADSQ_OFS_STAT, 32'h1);
        @(posedge mclk_i);
        stop_mode_i <= 1'b0;
        wait_irq();
        chk_rd("word_resume", `ADSQ_OFS_RESW, {16'h0, CODE1, 6'h0});
        // reads five cycles apart sweep every phase of the 14-cycle conversion
        hi = 0;
        repeat (14) begin
            rd(`ADSQ_OFS_RESW, d, r);
            `CHK("word_busy", {16'h0, CODE1, 6'h0}, d)
            @(negedge mclk_i);
            if (smp === 1'b1) hi++;
            @(posedge mclk_i);
        end
        `CHK("sample_share", 4, hi)
        // port writes five cycles apart, one meets an end of conversion
        repeat (14) begin
            wr(`ADSQ_OFS_PCFG, 32'h5);
            @(posedge mclk_i);
        end
        @(negedge mclk_i);
        `CHK("port_cfg", 3'h5, pc)
        tally_and_finish();
    end
endmodule
